// ---- iopd_pkg.sv ----
// Package holding register map, field layout and types of the I/O pin port.
package iopd_pkg;

  localparam int NPINS = 8;
  localparam int OE_SIGS = 16;

  // Word byte addresses of the port-form registers and of pin-form register 0.
  localparam logic [7:0] OFS_DM0 = 8'h00;
  localparam logic [7:0] OFS_DM1 = 8'h04;
  localparam logic [7:0] OFS_DM2 = 8'h08;
  localparam logic [7:0] OFS_OUT = 8'h0C;
  localparam logic [7:0] OFS_LVL = 8'h10;
  localparam logic [7:0] OFS_SLW = 8'h14;
  localparam logic [7:0] OFS_IBD = 8'h18;
  localparam logic [7:0] OFS_BIE = 8'h1C;
  localparam logic [7:0] OFS_REG = 8'h20;
  localparam logic [7:0] OFS_CTL = 8'h24;
  localparam logic [7:0] OFS_ITL = 8'h28;
  localparam logic [7:0] OFS_ITH = 8'h2C;
  localparam logic [7:0] OFS_IST = 8'h30;
  localparam logic [7:0] OFS_OSL = 8'h34;
  localparam logic [7:0] OFS_OSH = 8'h38;
  localparam logic [7:0] OFS_PIN0 = 8'h40;

  // Pin-form register fields.
  localparam int PF_OUT = 0;
  localparam int PF_LVL = 0;
  localparam int PF_DM = 1;
  localparam int PF_IBD = 4;
  localparam int PF_SLW = 5;
  localparam int PF_BIE = 6;
  localparam int PF_REG = 7;

  // Control register field.
  localparam int CTL_LVTTL = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    DM_HIZ_ANALOG = 3'b000,
    DM_HIZ_DIGITAL = 3'b001,
    DM_RES_UP = 3'b010,
    DM_RES_DOWN = 3'b011,
    DM_OD_LOW = 3'b100,
    DM_OD_HIGH = 3'b101,
    DM_STRONG = 3'b110,
    DM_RES_BOTH = 3'b111
  } iopd_dm_t;

  typedef enum logic [1:0] {
    IT_NONE = 2'b00,
    IT_RISE = 2'b01,
    IT_FALL = 2'b10,
    IT_BOTH = 2'b11
  } iopd_it_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } iopd_bus_t;

  // Per-pin drive controls presented to the pad cells.
  typedef struct packed {
    logic [NPINS-1:0] drive_hi;
    logic [NPINS-1:0] drive_lo;
    logic [NPINS-1:0] res_hi;
    logic [NPINS-1:0] res_lo;
    logic [NPINS-1:0] in_en;
    logic [NPINS-1:0] slow;
    logic [NPINS-1:0] regulated;
  } iopd_pad_t;

endpackage

// ---- iopd_port.sv ----
// Eight-pin digital I/O port with drive modes, pin interrupts and bus slave.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// R1 - Selector 000 keeps driver and input buffer off; reset default.
// R2 - Selector 001 keeps driver off, input buffer on.
// R3 - 010 resistive high/strong low; 011 strong high/resistive low.
// R4 - 100 floats on 1, strong low on 0; 101 strong high, floats on 0.
// R5 - 110 drives strong high and strong low.
// R6 - 111 always drives through resistor, up on 1, down on 0.
// R7 - Regulated special pins lose resistive modes 010, 011 and 111.
// R8 - All registers reachable in port form, one bit per pin; the code's OSL/OSH hold four select bits per pin and CTL one bit per port.
// R9 - Pin-form registers gather eight bits and share the same state.
// R10 - Bidirectional pins switch between input and drive by enable.
// R11 - Sixteen enable signals each routable to one or more pins.
// R12 - Per-pin edge rate applies only in strong and open drain; slow is also set on the strong leg of 010 and 011.
// R13 - Software picks slow below 1 MHz, fast up to 33 MHz.
// R14 - Each pin detects rising, falling, both or no edge.
// R15 - A configured edge sets the status bit and requests interrupt.
// R16 - Per-port event unit has its own request; status names pin.
// R17 - Edge detection works in every sleep mode.
// R18 - Only edges are detected, never levels.
// R19 - Per-port CMOS or LVTTL thresholds; inputs have hysteresis.
// R20 - Each input buffer can be disabled in any drive mode.
// R21 - Special pins choose supply or regulated high output level.
// R22 - Pin level read and output value written are separate registers.
// R23 - Status stays set until read; read clears; request while set.
module iopd_port #(
  parameter int NPINS = iopd_pkg::NPINS,
  parameter int OE_SIGS = iopd_pkg::OE_SIGS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and auxiliary control bus.
  input wire logic [NPINS-1:0] pin_i,
  input wire logic [OE_SIGS-1:0] aux_oe_i,
  input wire logic [NPINS-1:0] special_io_pin,
  // Pad controls and event request.
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  output iopd_pkg::iopd_pad_t pad_ctl,
  output logic lvttl_sel,
  output logic [NPINS-1:0] digital_in,
  output logic port_event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NPINS-1:0] dm0;
    logic [NPINS-1:0] dm1;
    logic [NPINS-1:0] dm2;
    logic [NPINS-1:0] port_out_value;
    logic [NPINS-1:0] pin_level_read;
    logic [NPINS-1:0] edge_rate_sel;
    logic [NPINS-1:0] ibuf_dis;
    logic [NPINS-1:0] bidir_en;
    logic [NPINS-1:0] reg_out;
    logic lvttl;
    logic [2*NPINS-1:0] int_type;
    logic [NPINS-1:0] int_stat;
    logic [4*NPINS-1:0] oe_sel;
    logic [NPINS-1:0] prev_in;
    iopd_pkg::iopd_bus_t bus;
    logic [31:0] rdata;
  } iopd_state_t;

  iopd_state_t st_r;
  iopd_state_t st_nxt;

  // Byte-lane merge used by every port-form write.
  function automatic logic [31:0] iopd_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive decode.
  logic [NPINS-1:0] ibuf_on;
  logic [NPINS-1:0] drv_hi;
  logic [NPINS-1:0] drv_lo;
  logic [NPINS-1:0] rs_hi;
  logic [NPINS-1:0] rs_lo;
  logic [NPINS-1:0] aux_oe;

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      logic [2:0] dm;
      logic d;
      logic dh;
      logic dl;
      logic rh;
      logic rl;
      dm = {st_r.dm2[i], st_r.dm1[i], st_r.dm0[i]};
      d = st_r.port_out_value[i];
      dh = 1'b0;
      dl = 1'b0;
      rh = 1'b0;
      rl = 1'b0;
      // Selected enable line for this pin from the auxiliary bus.
      aux_oe[i] = aux_oe_i[st_r.oe_sel[4*i +: 4]]; // see R11
      case (iopd_pkg::iopd_dm_t'(dm))
        iopd_pkg::DM_HIZ_ANALOG: ; // see R1
        iopd_pkg::DM_HIZ_DIGITAL: ; // see R2
        iopd_pkg::DM_RES_UP:
        begin
          rh = d; // see R3
          dl = ~d;
        end
        iopd_pkg::DM_RES_DOWN:
        begin
          dh = d; // see R3
          rl = ~d;
        end
        iopd_pkg::DM_OD_LOW: dl = ~d; // see R4
        iopd_pkg::DM_OD_HIGH: dh = d; // see R4
        iopd_pkg::DM_STRONG:
        begin
          dh = d; // see R5
          dl = ~d;
        end
        iopd_pkg::DM_RES_BOTH:
        begin
          rh = d; // see R6
          rl = ~d;
        end
        default: ;
      endcase
      // Regulated special pins cannot use resistive drive at all.
      if (special_io_pin[i] && st_r.reg_out[i])
      begin
        rh = 1'b0; // see R7
        rl = 1'b0;
      end
      // Bidirectional pins release the drive when their enable is low.
      if (st_r.bidir_en[i] && !aux_oe[i])
      begin
        dh = 1'b0; // see R10
        dl = 1'b0;
        rh = 1'b0;
        rl = 1'b0;
      end
      drv_hi[i] = dh;
      drv_lo[i] = dl;
      rs_hi[i] = rh;
      rs_lo[i] = rl;
      // Input buffer: off in analog mode or when disabled per pin.
      ibuf_on[i] = (dm != 3'b000) && !st_r.ibuf_dis[i]; // see R1, R20
    end
  end

  assign pin_o = drv_hi | rs_hi;
  assign pin_oe = drv_hi | drv_lo | rs_hi | rs_lo;
  assign pad_ctl.drive_hi = drv_hi;
  assign pad_ctl.drive_lo = drv_lo;
  assign pad_ctl.res_hi = rs_hi;
  assign pad_ctl.res_lo = rs_lo;
  assign pad_ctl.in_en = ibuf_on;
  // Edge rate only matters for strong drive; resistive legs ignore it.
  assign pad_ctl.slow = st_r.edge_rate_sel & (drv_hi | drv_lo); // see R12
  assign pad_ctl.regulated = st_r.reg_out & special_io_pin; // see R21
  assign lvttl_sel = st_r.lvttl; // see R19
  assign digital_in = st_r.pin_level_read;
  assign port_event_irq = |st_r.int_stat; // see R16, R23
  assign wb_ack_o = (st_r.bus == iopd_pkg::BUS_ACK);
  assign wb_dat_o = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection runs on every clock with no gating, so it keeps
  // working while the rest of the chip sleeps.
  logic [NPINS-1:0] cur_in;
  logic [NPINS-1:0] rise;
  logic [NPINS-1:0] fall;
  logic [NPINS-1:0] hit;

  always_comb
  begin
    cur_in = pin_i & ibuf_on; // see R2
    rise = cur_in & ~st_r.prev_in; // see R18
    fall = ~cur_in & st_r.prev_in;
    for (int i = 0; i < NPINS; i++)
    begin
      // Low half enables rising edges, high half falling edges, per pin.
      hit[i] = (st_r.int_type[i] && rise[i]) ||
               (st_r.int_type[NPINS+i] && fall[i]); // see R14, R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic req;
  logic [31:0] rd;
  logic [31:0] wv;

  always_comb
  begin
    int p;
    st_nxt = st_r;
    req = wb_cyc_i && wb_stb_i && (st_r.bus == iopd_pkg::BUS_IDLE);
    p = int'(wb_adr_i[4:2]);
    rd = iopd_pkg::RST_WORD;
    wv = wb_dat_i;
    st_nxt.prev_in = cur_in;
    st_nxt.pin_level_read = cur_in; // see R22
    st_nxt.bus = req ? iopd_pkg::BUS_ACK : iopd_pkg::BUS_IDLE;
    case (wb_adr_i)
      iopd_pkg::OFS_DM0: rd[NPINS-1:0] = st_r.dm0;
      iopd_pkg::OFS_DM1: rd[NPINS-1:0] = st_r.dm1;
      iopd_pkg::OFS_DM2: rd[NPINS-1:0] = st_r.dm2;
      iopd_pkg::OFS_OUT: rd[NPINS-1:0] = st_r.port_out_value;
      iopd_pkg::OFS_LVL: rd[NPINS-1:0] = st_r.pin_level_read; // see R22
      iopd_pkg::OFS_SLW: rd[NPINS-1:0] = st_r.edge_rate_sel;
      iopd_pkg::OFS_IBD: rd[NPINS-1:0] = st_r.ibuf_dis;
      iopd_pkg::OFS_BIE: rd[NPINS-1:0] = st_r.bidir_en;
      iopd_pkg::OFS_REG: rd[NPINS-1:0] = st_r.reg_out;
      iopd_pkg::OFS_CTL: rd[iopd_pkg::CTL_LVTTL] = st_r.lvttl;
      iopd_pkg::OFS_ITL: rd[NPINS-1:0] = st_r.int_type[NPINS-1:0];
      iopd_pkg::OFS_ITH: rd[NPINS-1:0] = st_r.int_type[2*NPINS-1:NPINS];
      iopd_pkg::OFS_IST: rd[NPINS-1:0] = st_r.int_stat;
      iopd_pkg::OFS_OSL: rd[15:0] = st_r.oe_sel[15:0];
      iopd_pkg::OFS_OSH: rd[15:0] = st_r.oe_sel[31:16];
      default:
      begin
        if (wb_adr_i[7:5] == iopd_pkg::OFS_PIN0[7:5])
        begin
          rd[iopd_pkg::PF_LVL] = st_r.pin_level_read[p]; // see R9
          rd[iopd_pkg::PF_DM+2 -: 3] = {st_r.dm2[p], st_r.dm1[p],
                                        st_r.dm0[p]};
          rd[iopd_pkg::PF_IBD] = st_r.ibuf_dis[p];
          rd[iopd_pkg::PF_SLW] = st_r.edge_rate_sel[p];
          rd[iopd_pkg::PF_BIE] = st_r.bidir_en[p];
          rd[iopd_pkg::PF_REG] = st_r.reg_out[p];
        end
      end
    endcase
    if (req && !wb_we_i)
    begin
      st_nxt.rdata = rd;
    end
    if (req && wb_we_i)
    begin
      wv = iopd_merge(rd, wb_dat_i, wb_sel_i); // see R8
      case (wb_adr_i)
        iopd_pkg::OFS_DM0: st_nxt.dm0 = wv[NPINS-1:0];
        iopd_pkg::OFS_DM1: st_nxt.dm1 = wv[NPINS-1:0];
        iopd_pkg::OFS_DM2: st_nxt.dm2 = wv[NPINS-1:0];
        iopd_pkg::OFS_OUT: st_nxt.port_out_value = wv[NPINS-1:0];
        iopd_pkg::OFS_SLW: st_nxt.edge_rate_sel = wv[NPINS-1:0];
        iopd_pkg::OFS_IBD: st_nxt.ibuf_dis = wv[NPINS-1:0];
        iopd_pkg::OFS_BIE: st_nxt.bidir_en = wv[NPINS-1:0];
        iopd_pkg::OFS_REG: st_nxt.reg_out = wv[NPINS-1:0];
        iopd_pkg::OFS_CTL: st_nxt.lvttl = wv[iopd_pkg::CTL_LVTTL];
        iopd_pkg::OFS_ITL: st_nxt.int_type[NPINS-1:0] = wv[NPINS-1:0];
        iopd_pkg::OFS_ITH:
          st_nxt.int_type[2*NPINS-1:NPINS] = wv[NPINS-1:0];
        iopd_pkg::OFS_OSL: st_nxt.oe_sel[15:0] = wv[15:0];
        iopd_pkg::OFS_OSH: st_nxt.oe_sel[31:16] = wv[15:0];
        default:
        begin
          // Pin form: bit 0 writes the output value, read back as level.
          if (wb_adr_i[7:5] == iopd_pkg::OFS_PIN0[7:5] && wb_sel_i[0])
          begin
            st_nxt.port_out_value[p] = wb_dat_i[iopd_pkg::PF_OUT]; // see R9
            st_nxt.dm0[p] = wb_dat_i[iopd_pkg::PF_DM];
            st_nxt.dm1[p] = wb_dat_i[iopd_pkg::PF_DM+1];
            st_nxt.dm2[p] = wb_dat_i[iopd_pkg::PF_DM+2];
            st_nxt.ibuf_dis[p] = wb_dat_i[iopd_pkg::PF_IBD];
            st_nxt.edge_rate_sel[p] = wb_dat_i[iopd_pkg::PF_SLW];
            st_nxt.bidir_en[p] = wb_dat_i[iopd_pkg::PF_BIE];
            st_nxt.reg_out[p] = wb_dat_i[iopd_pkg::PF_REG];
          end
        end
      endcase
    end
    // Read clears status, but a new edge in the same cycle survives.
    if (req && !wb_we_i && wb_adr_i == iopd_pkg::OFS_IST)
    begin
      st_nxt.int_stat = '0; // see R23
    end
    st_nxt.int_stat = st_nxt.int_stat | hit; // see R15
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0; // see R1
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// ---- iopd_ext_model.sv ----
// Model of the circuitry outside the pins: resolves each pin level.
`timescale 1ns/1ns
module iopd_ext_model (
  // Clock.
  input wire logic ref_clk,
  // Pad side.
  input wire logic [7:0] pin_o,
  input wire iopd_pkg::iopd_pad_t pad_ctl,
  // Test driver.
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  logic [7:0] float_r = 8'h55;
  // A floating pin toggles every cycle so a stale level is never trusted.
  always @(posedge ref_clk) float_r <= ~float_r;
  // Strong drive wins over the test driver, which wins over a resistor.
  always_comb
    for (int i = 0; i < 8; i++)
      if (pad_ctl.drive_hi[i] | pad_ctl.drive_lo[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pad_ctl.res_hi[i] | pad_ctl.res_lo[i]) pin_i[i] = pin_o[i];
      else pin_i[i] = float_r[i];
endmodule

// ---- iopd_port_properties.sv ----
// Checker of the port's bus handshake, pad controls and event request.
`timescale 1ns/1ns
module iopd_port_properties #(
  parameter int NPINS = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  // Pins and pads.
  input wire logic [NPINS-1:0] pin_i,
  input wire logic [NPINS-1:0] special_io_pin,
  input wire logic [NPINS-1:0] pin_o,
  input wire logic [NPINS-1:0] pin_oe,
  input wire iopd_pkg::iopd_pad_t pad_ctl,
  input wire logic [NPINS-1:0] digital_in,
  input wire logic port_event_irq
);
  logic [NPINS-1:0] smp_r;
  logic [NPINS-1:0] hi;
  logic [NPINS-1:0] lo;
  logic rst_q_r;
  logic st_rd;
  assign hi = pad_ctl.drive_hi | pad_ctl.res_hi;
  assign lo = pad_ctl.drive_lo | pad_ctl.res_lo;
  assign st_rd = wb_cyc_i & wb_stb_i & ~wb_we_i
    & (wb_adr_i == iopd_pkg::OFS_IST);
  always_ff @(posedge ref_clk)
  begin
    smp_r <= pin_i & pad_ctl.in_en;
    rst_q_r <= rst_n;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_take_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  oe_match_a: assert property (pin_oe == (hi | lo))
    else $error("output enable disagrees with pad drive");
  no_fight_a: assert property ((hi & lo) == '0)
    else $error("pin pulled both ways");
  data_sense_a: assert property (
    (hi & ~pin_o) == '0 && (lo & pin_o) == '0)
    else $error("drive direction disagrees with data");
  reg_nores_a: assert property (
    (pad_ctl.regulated & (pad_ctl.res_hi | pad_ctl.res_lo)) == '0)
    else $error("resistor on regulated pin");
  reg_special_a: assert property (
    (pad_ctl.regulated & ~special_io_pin) == '0)
    else $error("regulated level on ordinary pin");
  slow_strong_a: assert property (
    (pad_ctl.slow & ~(pad_ctl.drive_hi | pad_ctl.drive_lo)) == '0)
    else $error("slow edge outside strong drive");
  irq_hold_a: assert property (
    port_event_irq && !st_rd |=> port_event_irq)
    else $error("event request dropped without status read");
  in_sample_a: assert property (rst_q_r |-> digital_in == smp_r)
    else $error("input seen through disabled buffer");
endmodule
bind iopd_port iopd_port_properties #(.NPINS(NPINS)) u_iopd_port_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .pin_i(pin_i), .special_io_pin(special_io_pin),
  .pin_o(pin_o), .pin_oe(pin_oe), .pad_ctl(pad_ctl),
  .digital_in(digital_in), .port_event_irq(port_event_irq));

// ---- tb_top.sv ----
// Self-checking bench for the eight-pin port.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    n_checks++; \
    if ((gt) !== (ex)) \
    begin \
      err_count++; \
      $display("FAIL %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_top;
  import iopd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, lvttl, irq;
  logic [7:0] wb_adr = 8'h00, special = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, pin_i, pin_o, pin_oe, din, o;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rdq, sv;
  logic [15:0] aux_oe = 16'h0000;
  logic [4:0] e;
  logic [2:0] m;
  iopd_pad_t pad;
  int err_count = 0, n_checks = 0, p;
  always #20 ref_clk = ~ref_clk;
  iopd_port u_iopd_port (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pin_i(pin_i),
    .aux_oe_i(aux_oe), .special_io_pin(special), .pin_o(pin_o),
    .pin_oe(pin_oe), .pad_ctl(pad), .lvttl_sel(lvttl), .digital_in(din),
    .port_event_irq(irq));
  iopd_ext_model u_iopd_ext_model (.ref_clk(ref_clk), .pin_o(pin_o),
    .pad_ctl(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
  ////////////////////////////////////////
  task automatic complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge ref_clk);
    while (wb_ack !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 40)
    begin
      err_count++;
      complete_run();
    end
    rdq = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic mode_all(input logic [2:0] md);
    bus(1'b1, OFS_DM0, {24'h0, {8{md[0]}}});
    bus(1'b1, OFS_DM1, {24'h0, {8{md[1]}}});
    bus(1'b1, OFS_DM2, {24'h0, {8{md[2]}}});
  endtask
  // Drive high, drive low, resistor up, resistor down, input enable.
  function automatic logic [4:0] exp_pad(input logic [2:0] md, input logic d);
    return {d & (md == 3'h3 || md == 3'h5 || md == 3'h6),
      ~d & (md == 3'h2 || md == 3'h4 || md == 3'h6),
      d & (md == 3'h2 || md == 3'h7), ~d & (md == 3'h3 || md == 3'h7),
      md != 3'h0};
  endfunction
  function automatic logic [7:0] exp_oe(input logic [31:0] s,
    input logic [15:0] a);
    for (int i = 0; i < 8; i++)
      exp_oe[i] = a[s[4 * i +: 4]];
  endfunction
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(55060));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK("pin_oe", 8'h00, pin_oe)
    for (int a = 0; a < 'h40; a += 4)
    begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK("reset word", RST_WORD, rdq)
    end
    for (int k = 0; k < 16; k++)
    begin
      p = $urandom_range(7);
      m = k[3:1];
      e = exp_pad(m, k[0]);
      bus(1'b1, OFS_PIN0 + 8'(4 * p), (32'(m) << PF_DM) | 32'(k[0]));
      `CHK("pad", e, {pad.drive_hi[p], pad.drive_lo[p], pad.res_hi[p], pad.res_lo[p], pad.in_en[p]})
      `CHK("oe", |e[4:1], pin_oe[p])
      `CHK("pin out", e[4] | e[2], pin_o[p])
      bus(1'b0, OFS_DM2, 32'h0);
      `CHK("port dm2", m[2], rdq[p])
      bus(1'b0, OFS_DM0, 32'h0);
      `CHK("port dm0", m[0], rdq[p])
    end
    mode_all(3'h1);
    ext_en <= 8'hFF;
    ext_val <= 8'($urandom);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, OFS_LVL, 32'h0);
    `CHK("level", ext_val, rdq[7:0])
    p = $urandom_range(7);
    bus(1'b0, OFS_PIN0 + 8'(4 * p), 32'h0);
    `CHK("pin level", ext_val[p], rdq[0])
    bus(1'b1, OFS_IBD, 32'hFF);
    `CHK("ibuf off", 8'h00, pad.in_en)
    bus(1'b0, OFS_LVL, 32'h0);
    `CHK("level off", 32'h0, rdq)
    bus(1'b1, OFS_IBD, 32'h0);
    mode_all(3'h6);
    bus(1'b1, OFS_SLW, 32'hFF);
    `CHK("slow strong", 8'hFF, pad.slow)
    o = 8'($urandom);
    bus(1'b1, OFS_OUT, {24'h0, o});
    bus(1'b1, OFS_DM2, 32'h0);
    `CHK("slow res", ~o, pad.slow)
    `CHK("res up", o, pad.res_hi)
    special <= 8'h0F;
    mode_all(3'h7);
    bus(1'b1, OFS_REG, 32'hFF);
    `CHK("regulated", 8'h0F, pad.regulated)
    `CHK("res legs", 8'hF0, pad.res_hi | pad.res_lo)
    bus(1'b1, OFS_REG, 32'h0);
    bus(1'b1, OFS_CTL, 32'h1);
    `CHK("lvttl", 1'b1, lvttl)
    mode_all(3'h6);
    bus(1'b1, OFS_BIE, 32'hFF);
    sv = $urandom;
    bus(1'b1, OFS_OSL, {16'h0, sv[15:0]});
    bus(1'b1, OFS_OSH, {16'h0, sv[31:16]});
    repeat (4)
    begin
      aux_oe <= 16'($urandom);
      repeat (2) @(posedge ref_clk);
      `CHK("bidir oe", exp_oe(sv, aux_oe), pin_oe)
    end
    bus(1'b1, OFS_BIE, 32'h0);
    mode_all(3'h1);
    ext_val <= 8'h00;
    for (int t = 0; t < 4; t++)
    begin
      p = $urandom_range(7);
      bus(1'b1, OFS_ITL, 32'(t[0]) << p);
      bus(1'b1, OFS_ITH, 32'(t[1]) << p);
      bus(1'b0, OFS_IST, 32'h0);
      for (int v = 1; v >= 0; v--)
      begin
        ext_val[p] <= v[0];
        repeat (4) @(posedge ref_clk);
        `CHK("irq", t[1 - v], irq)
        bus(1'b0, OFS_IST, 32'h0);
        `CHK("status", 32'(t[1 - v]) << p, rdq)
        `CHK("irq clear", 1'b0, irq)
      end
    end
    complete_run();
  end
endmodule
